// ---- hw/mhc_mailbox.sv ----
// Mailbox header codec: APB register file, shared mailbox memory,
// outgoing status byte encoder, host message capture and loader status.
// Assumes all non-APB inputs come from device logic on mclk.
//
// Operation
// R1: Paths 1-3 status byte: selector bits 7:6, code, source bits 1:0.
// R2: Source 00 buffer, 01 framer, 10 pump, 11 serial bus.
// R3: Paths 1-3 receive data with framer event uses low bits 100000.
// R4: Paths 1-3 configuration data uses code 1001.
// R5: Paths 1-3 status event uses code 1010.
// R6: Paths 1-3 requested status information uses code 1011.
// R7: Buffer available for any path is the all-zero status byte.
// R8: Path 0 messages put 00 in bits 7:6 and a 6-bit code.
// R9: Path 0 codes 101000, 111101, 111110 for bus cfg and buffer status.
// R10: Path 0 codes selftest, version, invalid and pin status.
// R11: Path 0 monitor codes 110001, 110000, 110010.
// R12: Timer event is the fixed byte 01101010 on path 1.
// R13: Host discards messages with undefined status codes.
// R14: Upper control byte carries message dependent content.
// R15: Lower control byte counts mailbox data bytes, zero when none.
// R16: Parameter bytes follow a per-message layout.
// R17: Chip version is checked automatically during program load.
// R18: Host reads loader status before continuing.
// R19: Selftest runs at load end; host requests its result.
// R20: Host configures buffer, pump, serial bus, framer in order.
// R21: Pump configuration resets the datapath except buffer config.
// R22: Host status byte written last sets busy; device clears it.
// R23: Host clearing the ack bit releases the whole mailbox.
// R24: Pending flag set on new message; line driven only if unmasked.
// R25: Data reached through auto-incrementing read and write pointers.
// R26: Byte count is an unsigned 8-bit value.
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
module mhc_mailbox (
    input  wire logic                    mclk,
    input  wire logic                    rst_b,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [mhc_pkg::PADDR_W-1:0] paddr,
    input  wire logic [mhc_pkg::PDATA_W-1:0] pwdata,
    output logic      [mhc_pkg::PDATA_W-1:0] prdata,
    output logic                         pready,
    output logic                         pslverr,
    output logic                         irq,
    input  wire logic                    tx_req,
    input  wire mhc_pkg::mhc_kind_e      tx_kind,
    input  wire logic [1:0]              tx_path,
    input  wire logic [1:0]              tx_src,
    input  wire logic [7:0]              tx_ctrl_hi,
    input  wire logic [7:0]              tx_count,
    output logic                         tx_ready,
    output logic                         tx_reject,
    input  wire logic                    dev_mem_we,
    input  wire logic [7:0]              dev_mem_addr,
    input  wire logic [7:0]              dev_mem_wdata,
    output logic      [7:0]              dev_mem_rdata,
    output logic                         rx_msg,
    output logic      [7:0]              rx_his,
    output logic      [7:0]              rx_ctrl_hi,
    output logic      [7:0]              rx_count,
    input  wire logic                    rx_done,
    output logic                         dp_reset,
    output logic      [1:0]              dp_reset_path,
    input  wire logic                    load_done,
    input  wire logic [7:0]              load_chip_ver,
    input  wire logic                    selftest_ok
);
    import mhc_pkg::*;

    // ************************************************************
    // Status byte encoder
    // ************************************************************
    function automatic logic [8:0] mhc_encode(input mhc_kind_e k,
                                              input logic [1:0] p,
                                              input logic [1:0] s);
        logic       ok;
        logic [7:0] b;
        ok = 1'b1;
        b  = BYTE_RST;
        unique case (k)
            MHC_BUF_AVAIL: b = DIS_BUF_AVAIL;                    // R7
            MHC_RX_FRAMER: begin
                ok = (p != PATH_0);
                b  = {p, MSC_RX_FRAMER};                         // R3
            end
            MHC_CFG: begin
                ok = (p != PATH_0);
                b  = {p, MSC_CFG, s};                            // R2 R4
            end
            MHC_EVT: begin
                ok = (p != PATH_0);
                b  = {p, MSC_EVT, s};                            // R5
            end
            MHC_INFO: begin
                ok = (p != PATH_0);
                b  = {p, MSC_INFO, s};                           // R6
            end
            MHC_TDBUS_CFG: b = {PATH_0, P0_TDBUS_CFG};           // R8 R9
            MHC_BUF_RSP:   b = {PATH_0, P0_BUF_RSP};             // R9
            MHC_BUF_EVT:   b = {PATH_0, P0_BUF_EVT};             // R9
            MHC_INVALID:   b = {PATH_0, P0_INVALID};             // R10
            MHC_SELFTEST:  b = {PATH_0, P0_SELFTEST};            // R10
            MHC_VERSION:   b = {PATH_0, P0_VERSION};             // R10
            MHC_GPIO:      b = {PATH_0, P0_GPIO};                // R10
            MHC_MON_CFG:   b = {PATH_0, P0_MON_CFG};             // R11
            MHC_MON_RX:    b = {PATH_0, P0_MON_RX};              // R11
            MHC_MON_EVT:   b = {PATH_0, P0_MON_EVT};             // R11
            MHC_TIMER:     b = DIS_TIMER;                        // R12
        endcase
        return {ok, b};
    endfunction

    // ************************************************************
    // APB access phase
    // ************************************************************
    logic       acc;
    logic       wr_acc;
    logic       rd_acc;
    logic       addr_ok;
    logic [7:0] wbyte;
    logic [8:0] enc;
    logic       post;
    logic       release_mb;
    logic       his_wr;

    logic [7:0] rd_ptr_reg;
    logic [7:0] wr_ptr_reg;
    logic [7:0] dis_reg;
    logic [7:0] ctrl_hi_reg;
    logic [7:0] ctrl_lo_reg;
    logic [7:0] his_reg;
    logic       busy_reg;
    logic       ack_reg;
    logic       pend_reg;
    logic       mask_reg;
    logic       ld_done_reg;
    logic       ld_ver_reg;
    logic       ld_st_reg;
    logic [7:0] mbox_mem [MBOX_DEPTH];
    logic [31:0] rdata_next;

    assign acc    = psel & penable & pready;
    assign wr_acc = acc & pwrite;
    assign rd_acc = acc & ~pwrite;
    assign wbyte  = pwdata[7:0];

    always_comb begin
        addr_ok = 1'b1;
        unique case (paddr)
            ADDR_RD_PTR,
            ADDR_WR_PTR,
            ADDR_DATA,
            ADDR_DIS,
            ADDR_CTRLHI,
            ADDR_CTRLLO,
            ADDR_HIS,
            ADDR_FLAGS,
            ADDR_LOADER: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    always_comb begin
        rdata_next = WORD_RST;
        unique case (paddr)
            ADDR_RD_PTR: rdata_next[7:0] = rd_ptr_reg;
            ADDR_WR_PTR: rdata_next[7:0] = wr_ptr_reg;
            ADDR_DATA:   rdata_next[7:0] = mbox_mem[rd_ptr_reg];
            ADDR_DIS:    rdata_next[7:0] = dis_reg;
            ADDR_CTRLHI: rdata_next[7:0] = ctrl_hi_reg;
            ADDR_CTRLLO: rdata_next[7:0] = ctrl_lo_reg;
            ADDR_HIS:    rdata_next[7:0] = his_reg;
            ADDR_FLAGS: begin
                rdata_next[FLG_BUSY] = busy_reg;
                rdata_next[FLG_ACK]  = ack_reg;
                rdata_next[FLG_PEND] = pend_reg;
                rdata_next[FLG_MASK] = mask_reg;
            end
            ADDR_LOADER: begin
                rdata_next[LDR_DONE] = ld_done_reg;
                rdata_next[LDR_VER]  = ld_ver_reg;
                rdata_next[LDR_ST]   = ld_st_reg;
                rdata_next[LDR_OK]   = ld_done_reg & ld_ver_reg & ld_st_reg;
            end
            default: rdata_next = WORD_RST;
        endcase
    end

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= WORD_RST;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= ~addr_ok;
            prdata  <= pwrite ? WORD_RST : rdata_next;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ************************************************************
    // Mailbox memory and pointers
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (wr_acc && paddr == ADDR_DATA) begin
            mbox_mem[wr_ptr_reg] <= wbyte;                       // R25
        end else if (dev_mem_we) begin
            mbox_mem[dev_mem_addr] <= dev_mem_wdata;             // R16
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dev_mem_rdata <= BYTE_RST;
        end else begin
            dev_mem_rdata <= mbox_mem[dev_mem_addr];
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rd_ptr_reg <= BYTE_RST;
            wr_ptr_reg <= BYTE_RST;
        end else begin
            if (wr_acc && paddr == ADDR_RD_PTR) begin
                rd_ptr_reg <= wbyte;
            end else if (rd_acc && paddr == ADDR_DATA) begin
                rd_ptr_reg <= rd_ptr_reg + 8'h01;                // R25
            end
            if (wr_acc && paddr == ADDR_WR_PTR) begin
                wr_ptr_reg <= wbyte;
            end else if (wr_acc && paddr == ADDR_DATA) begin
                wr_ptr_reg <= wr_ptr_reg + 8'h01;                // R25
            end
        end
    end

    // ************************************************************
    // Device to host message
    // ************************************************************
    assign enc        = mhc_encode(tx_kind, tx_path, tx_src);
    assign post       = tx_req & tx_ready & enc[8];
    assign release_mb = wr_acc & (paddr == ADDR_FLAGS)
                        & ~wbyte[FLG_ACK] & ack_reg;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dis_reg   <= BYTE_RST;
            tx_reject <= 1'b0;
        end else begin
            tx_reject <= tx_req & ~post;
            if (post) begin
                dis_reg <= enc[7:0];                             // R1
            end
        end
    end

    // Device posting wins over a host write in the same cycle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_hi_reg <= BYTE_RST;
            ctrl_lo_reg <= BYTE_RST;
        end else if (post) begin
            ctrl_hi_reg <= tx_ctrl_hi;                           // R14
            ctrl_lo_reg <= tx_count;                             // R15 R26
        end else begin
            if (wr_acc && paddr == ADDR_CTRLHI) begin
                ctrl_hi_reg <= wbyte;                            // R14
            end
            if (wr_acc && paddr == ADDR_CTRLLO) begin
                ctrl_lo_reg <= wbyte;                            // R15 R26
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ack_reg  <= 1'b0;
            pend_reg <= 1'b0;
            tx_ready <= 1'b1;
        end else if (post) begin
            ack_reg  <= 1'b1;
            pend_reg <= 1'b1;                                    // R24
            tx_ready <= 1'b0;
        end else if (release_mb) begin
            ack_reg  <= 1'b0;                                    // R23
            pend_reg <= 1'b0;
            tx_ready <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mask_reg <= 1'b0;
            irq      <= 1'b0;
        end else begin
            if (wr_acc && paddr == ADDR_FLAGS) begin
                mask_reg <= wbyte[FLG_MASK];
            end
            irq <= pend_reg & mask_reg;                          // R24
        end
    end

    // ************************************************************
    // Host to device message
    // ************************************************************
    assign his_wr = wr_acc & (paddr == ADDR_HIS) & ~busy_reg;

    // Set by the host write wins over the device clear
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            busy_reg <= 1'b0;
        end else if (his_wr) begin
            busy_reg <= 1'b1;                                    // R22
        end else if (rx_done) begin
            busy_reg <= 1'b0;                                    // R22
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            his_reg    <= BYTE_RST;
            rx_msg     <= 1'b0;
            rx_his     <= BYTE_RST;
            rx_ctrl_hi <= BYTE_RST;
            rx_count   <= BYTE_RST;
        end else begin
            rx_msg <= his_wr;
            if (his_wr) begin
                his_reg    <= wbyte;
                rx_his     <= wbyte;                             // R22
                rx_ctrl_hi <= ctrl_hi_reg;
                rx_count   <= ctrl_lo_reg;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dp_reset      <= 1'b0;
            dp_reset_path <= PATH_0;
        end else begin
            dp_reset <= his_wr
                        && wbyte[DPS_HI:DPS_LO] != PATH_0
                        && wbyte[MSC_HI:MSC_LO] == HOST_PUMP_CFG
                        && wbyte[SRC_HI:SRC_LO] == SRC_PUMP;     // R21
            if (his_wr) begin
                dp_reset_path <= wbyte[DPS_HI:DPS_LO];
            end
        end
    end

    // ************************************************************
    // Loader status
    // ************************************************************
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ld_done_reg <= 1'b0;
            ld_ver_reg  <= 1'b0;
            ld_st_reg   <= 1'b0;
        end else if (load_done) begin
            ld_done_reg <= 1'b1;                                 // R18
            ld_ver_reg  <= (load_chip_ver == CHIP_VERSION);      // R17
            ld_st_reg   <= selftest_ok;                          // R19
        end
    end

endmodule

// ---- include/mhc_pkg.sv ----
// Constants, register map and message kinds of the mailbox header codec.
// Assumes a single 100 MHz clock domain and an APB master on the bus side.
package mhc_pkg;

    // ************************************************************
    // Bus and register map
    // ************************************************************
    localparam int unsigned PADDR_W   = 8;
    localparam int unsigned PDATA_W   = 32;
    localparam logic [7:0] IDX_RD_PTR = 8'h00;
    localparam logic [7:0] IDX_WR_PTR = 8'h01;
    localparam logic [7:0] IDX_DATA   = 8'h02;
    localparam logic [7:0] IDX_DIS    = 8'h03;
    localparam logic [7:0] IDX_CTRLHI = 8'h04;
    localparam logic [7:0] IDX_CTRLLO = 8'h05;
    localparam logic [7:0] IDX_HIS    = 8'h06;
    localparam logic [7:0] IDX_FLAGS  = 8'h07;
    localparam logic [7:0] IDX_LOADER = 8'h08;
    localparam logic [7:0] ADDR_RD_PTR = 8'(IDX_RD_PTR * 4);
    localparam logic [7:0] ADDR_WR_PTR = 8'(IDX_WR_PTR * 4);
    localparam logic [7:0] ADDR_DATA   = 8'(IDX_DATA * 4);
    localparam logic [7:0] ADDR_DIS    = 8'(IDX_DIS * 4);
    localparam logic [7:0] ADDR_CTRLHI = 8'(IDX_CTRLHI * 4);
    localparam logic [7:0] ADDR_CTRLLO = 8'(IDX_CTRLLO * 4);
    localparam logic [7:0] ADDR_HIS    = 8'(IDX_HIS * 4);
    localparam logic [7:0] ADDR_FLAGS  = 8'(IDX_FLAGS * 4);
    localparam logic [7:0] ADDR_LOADER = 8'(IDX_LOADER * 4);

    // Flag register bits
    localparam int unsigned FLG_BUSY = 0;
    localparam int unsigned FLG_ACK  = 1;
    localparam int unsigned FLG_PEND = 2;
    localparam int unsigned FLG_MASK = 3;
    // Loader status bits
    localparam int unsigned LDR_DONE = 0;
    localparam int unsigned LDR_VER  = 1;
    localparam int unsigned LDR_ST   = 2;
    localparam int unsigned LDR_OK   = 3;

    localparam logic [7:0]  BYTE_RST = 8'h00;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam int unsigned MBOX_DEPTH = 256;

    // ************************************************************
    // Status byte fields and codes
    // ************************************************************
    localparam int unsigned DPS_HI = 7;
    localparam int unsigned DPS_LO = 6;
    localparam int unsigned MSC_HI = 5;
    localparam int unsigned MSC_LO = 2;
    localparam int unsigned SRC_HI = 1;
    localparam int unsigned SRC_LO = 0;

    localparam logic [1:0] PATH_0 = 2'h0;
    localparam logic [1:0] SRC_BUFFER = 2'h0;
    localparam logic [1:0] SRC_FRAMER = 2'h1;
    localparam logic [1:0] SRC_PUMP   = 2'h2;
    localparam logic [1:0] SRC_TDBUS  = 2'h3;

    localparam logic [5:0] MSC_RX_FRAMER = 6'h20;
    localparam logic [3:0] MSC_CFG       = 4'h9;
    localparam logic [3:0] MSC_EVT       = 4'hA;
    localparam logic [3:0] MSC_INFO      = 4'hB;
    localparam logic [7:0] DIS_BUF_AVAIL = 8'h00;
    localparam logic [7:0] DIS_TIMER     = 8'h6A;
    localparam logic [5:0] P0_TDBUS_CFG  = 6'h28;
    localparam logic [5:0] P0_BUF_RSP    = 6'h3D;
    localparam logic [5:0] P0_BUF_EVT    = 6'h3E;
    localparam logic [5:0] P0_INVALID    = 6'h3F;
    localparam logic [5:0] P0_SELFTEST   = 6'h24;
    localparam logic [5:0] P0_VERSION    = 6'h25;
    localparam logic [5:0] P0_GPIO       = 6'h2A;
    localparam logic [5:0] P0_MON_CFG    = 6'h31;
    localparam logic [5:0] P0_MON_RX     = 6'h30;
    localparam logic [5:0] P0_MON_EVT    = 6'h32;

    // Host code field that marks a pump configuration setup
    localparam logic [3:0] HOST_PUMP_CFG = 4'h1;
    // Expected chip version, value arbitrary
    localparam logic [7:0] CHIP_VERSION  = 8'h5A;

    typedef enum logic [3:0] {
        MHC_BUF_AVAIL, MHC_RX_FRAMER, MHC_CFG, MHC_EVT, MHC_INFO,
        MHC_TDBUS_CFG, MHC_BUF_RSP, MHC_BUF_EVT, MHC_INVALID,
        MHC_SELFTEST, MHC_VERSION, MHC_GPIO, MHC_MON_CFG, MHC_MON_RX,
        MHC_MON_EVT, MHC_TIMER
    } mhc_kind_e;

endpackage

// ---- testbench/mhc_host_model.sv ----
// Host processor model: one APB transfer for each go request.
// Assumes the codec answers with pready; holds the request until then.
module mhc_host_model (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        go,
    input  wire logic        wr,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    output logic             done,
    output logic [31:0]      rdata,
    output logic             err,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            {psel, penable, pwrite, done, err} <= 5'h00;
            paddr <= 8'h00;
            pwdata <= 32'h0000_0000;
            rdata <= 32'h0000_0000;
        end else begin
            done <= 1'b0;
            if (go && !psel) begin
                psel <= 1'b1;
                pwrite <= wr;
                paddr <= addr;
                pwdata <= wdata;
            end else if (psel && !penable) begin
                penable <= 1'b1;
            end else if (psel && pready) begin
                {psel, penable, done} <= 3'h1;
                rdata <= prdata;
                err <= pslverr;
                paddr <= ~paddr;
                pwdata <= ~pwdata;
            end
        end
    end
endmodule

// ---- testbench/mhc_mailbox_bench.sv ----
// Self-checking bench of the mailbox header codec over APB.
// Assumes the codec, host model and checker are compiled before it.
module mhc_mailbox_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import mhc_pkg::*;
    logic        mclk = 1'b0, rst_b = 1'b0, go = 1'b0, wr = 1'b0;
    logic        tx_req = 1'b0, rx_done = 1'b0, dev_mem_we = 1'b0;
    logic        load_done = 1'b0, selftest_ok = 1'b0;
    logic [7:0]  addr = 8'h00, tx_ctrl_hi = 8'h00, tx_count = 8'h00;
    logic [7:0]  dev_mem_addr = 8'h00, dev_mem_wdata = 8'h00;
    logic [7:0]  load_chip_ver = 8'h00, n, e, paddr, dev_mem_rdata;
    logic [7:0]  rx_his, rx_ctrl_hi, rx_count;
    logic [31:0] wdata = 32'h0000_0000, pwdata, prdata, rdata;
    logic [1:0]  tx_path = 2'h0, tx_src = 2'h0, p, s, dp_reset_path;
    mhc_kind_e   tx_kind = MHC_BUF_AVAIL;
    logic        psel, penable, pwrite, pready, pslverr, irq, done, err;
    logic        tx_ready, tx_reject, rx_msg, dp_reset;
    int          n_fail = 0;
    int          n_compared = 0;
    localparam logic [7:0] CODE [16] = '{8'h00, 8'h20, 8'h24, 8'h28,
        8'h2C, 8'h28, 8'h3D, 8'h3E, 8'h3F, 8'h24, 8'h25, 8'h2A,
        8'h31, 8'h30, 8'h32, 8'h6A};
    always #5 mclk = ~mclk;
    mhc_mailbox mhc_mailbox_inst (.mclk, .rst_b, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .tx_req, .tx_kind,
        .tx_path, .tx_src, .tx_ctrl_hi, .tx_count, .tx_ready, .tx_reject,
        .dev_mem_we, .dev_mem_addr, .dev_mem_wdata, .dev_mem_rdata, .rx_msg,
        .rx_his, .rx_ctrl_hi, .rx_count, .rx_done, .dp_reset, .dp_reset_path,
        .load_done, .load_chip_ver, .selftest_ok);
    mhc_host_model mhc_host_model_inst (.mclk, .rst_b, .go, .wr, .addr,
        .wdata, .done, .rdata, .err, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr);
    task automatic tally_and_finish();
        if (n_fail == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] x, logic [31:0] g);
        n_compared++;
        if (g !== {24'h00_0000, x}) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, d);
        int i;
        go <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= 32'(d);
        tick();
        go <= 1'b0;
        for (i = 0; i < 20 && done !== 1'b1; i++)
            tick();
        if (i == 20) begin
            n_fail++;
            tally_and_finish();
        end
    endtask
    task automatic rdchk(input logic [7:0] a, x, input string nm);
        xfer(1'b0, a, 8'h00);
        chk(nm, x, rdata);
    endtask
    task automatic post(input mhc_kind_e k, input logic [1:0] pp, ss,
                        input logic [7:0] nn, input logic rej);
        tick();
        tx_req <= 1'b1;
        tx_kind <= k;
        tx_path <= pp;
        tx_src <= ss;
        tx_ctrl_hi <= ~nn;
        tx_count <= nn;
        tick();
        tx_req <= 1'b0;
        chk("tx_reject", 8'(rej), 32'(tx_reject));
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        tick();
        rdchk(ADDR_FLAGS, 8'h00, "flags");
        xfer(1'b0, 8'h40, 8'h00);
        chk("slverr", 8'h01, 32'(err));
        load_chip_ver <= CHIP_VERSION;
        selftest_ok <= 1'b1;
        load_done <= 1'b1;
        tick();
        load_done <= 1'b0;
        rdchk(ADDR_LOADER, 8'h0F, "loader");
        for (int k = 0; k < 20; k++) begin
            p = 2'(k % 3 + 1);
            s = 2'(k >> 3) + 2'(k);
            n = 8'(k * 17);
            e = CODE[k % 16];
            if (k % 16 inside {[1:4]})
                e = {p, e[5:2], (k % 16 == 1) ? 2'h0 : s};
            xfer(1'b1, ADDR_FLAGS, {4'h0, k[0], 3'h0});
            post(mhc_kind_e'(k % 16), p, s, n, 1'b0);
            rdchk(ADDR_FLAGS, {4'h0, k[0], 3'h6}, "flags");
            chk("irq", 8'(k[0]), 32'(irq));
            xfer(1'b1, ADDR_DIS, 8'hFF);
            rdchk(ADDR_DIS, e, "status");
            rdchk(ADDR_CTRLHI, ~n, "ctrl_hi");
            rdchk(ADDR_CTRLLO, n, "count");
            xfer(1'b1, ADDR_FLAGS, {4'h0, k[0], 3'h0});
            rdchk(ADDR_FLAGS, {4'h0, k[0], 3'h0}, "flags");
        end
        post(MHC_CFG, 2'h0, 2'h0, 8'h00, 1'b1);
        post(MHC_TIMER, 2'h0, 2'h0, 8'h00, 1'b0);
        post(MHC_EVT, 2'h1, 2'h0, 8'h00, 1'b1);
        xfer(1'b1, ADDR_FLAGS, 8'h00);
        xfer(1'b1, ADDR_CTRLLO, 8'h02);
        xfer(1'b1, ADDR_HIS, 8'h46);
        chk("rx_msg", 8'h01, 32'(rx_msg));
        chk("dp_reset", 8'h01, 32'(dp_reset));
        chk("dp_path", 8'h01, 32'(dp_reset_path));
        chk("rx_his", 8'h46, 32'(rx_his));
        chk("rx_ctrl_hi", 8'hFF, 32'(rx_ctrl_hi));
        chk("rx_count", 8'h02, 32'(rx_count));
        rdchk(ADDR_FLAGS, 8'h01, "flags");
        xfer(1'b1, ADDR_HIS, 8'h09);
        chk("rx_msg", 8'h00, 32'(rx_msg));
        rx_done <= 1'b1;
        tick();
        rx_done <= 1'b0;
        rdchk(ADDR_FLAGS, 8'h00, "flags");
        xfer(1'b1, ADDR_HIS, 8'h26);
        chk("dp_reset", 8'h00, 32'(dp_reset));
        dev_mem_we <= 1'b1;
        dev_mem_wdata <= 8'h77;
        tick();
        dev_mem_we <= 1'b0;
        xfer(1'b1, ADDR_RD_PTR, 8'h00);
        rdchk(ADDR_DATA, 8'h77, "data");
        chk("dev_rdata", 8'h77, 32'(dev_mem_rdata));
        rdchk(ADDR_RD_PTR, 8'h01, "rd_ptr");
        tally_and_finish();
    end
endmodule
bind mhc_mailbox mhc_mailbox_properties mhc_mailbox_properties_inst (
    .mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .irq, .tx_req, .tx_kind, .tx_path, .tx_ready, .tx_reject,
    .rx_msg, .dp_reset);

// ---- testbench/mhc_mailbox_properties.sv ----
// Port checker of the mailbox header codec.
// Assumes it is bound to mhc_mailbox and sees only its ports.
module mhc_mailbox_properties (
    input wire logic               mclk,
    input wire logic               rst_b,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [7:0]         paddr,
    input wire logic [31:0]        pwdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic               irq,
    input wire logic               tx_req,
    input wire mhc_pkg::mhc_kind_e tx_kind,
    input wire logic [1:0]         tx_path,
    input wire logic               tx_ready,
    input wire logic               tx_reject,
    input wire logic               rx_msg,
    input wire logic               dp_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    import mhc_pkg::*;
    logic acc_end;
    logic legal;
    assign acc_end = psel && penable && pready;
    assign legal = tx_path != 2'h0 || !(tx_kind inside
        {MHC_RX_FRAMER, MHC_CFG, MHC_EVT, MHC_INFO});
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    AST_PREADY_WAIT: assert property (psel && $rose(penable) |=> pready)
        else $error("pready late");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready too long");
    AST_SLVERR: assert property (pslverr |-> pready
        && (paddr > ADDR_LOADER || paddr[1:0] != 2'h0))
        else $error("error on mapped address");
    AST_RX_CAUSE: assert property (rx_msg |->
        $past(acc_end && pwrite && paddr == ADDR_HIS))
        else $error("rx_msg without status byte write");
    AST_DP_CAUSE: assert property (dp_reset |-> rx_msg &&
        $past(pwdata[7:6] != 2'h0 && pwdata[5:0] == {HOST_PUMP_CFG, 2'h2}))
        else $error("datapath reset without pump setup");
    AST_POST: assert property (tx_req && tx_ready && legal |=>
        !tx_ready && !tx_reject)
        else $error("legal post not taken");
    AST_REJECT: assert property (tx_req && !(tx_ready && legal) |=>
        tx_reject)
        else $error("bad post not refused");
    AST_IRQ: assert property ($rose(irq) |-> !$past(tx_ready))
        else $error("irq without message");
    AST_RELEASE: assert property (acc_end && pwrite &&
        paddr == ADDR_FLAGS && !pwdata[FLG_ACK] |=> ##[0:1] tx_ready)
        else $error("mailbox not released");
endmodule
